//--- core/badc_pkg.sv
// Purpose: shared constants and types for the board address decode and control block
// Assumes: 100 MHz board clock, 24-bit processor address
// Notes: decode table entry encoding is local to this design
package badc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Access times of the on-board memories, tunable per fitted parts
  localparam int unsigned RAM_ACCESS_NS = 20;
  localparam int unsigned ROM_ACCESS_NS = 50;
  localparam int unsigned RAM_WAIT_CYC = (RAM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ROM_WAIT_CYC = (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W = 4;
  localparam logic [WAIT_W-1:0] RAM_WAIT = WAIT_W'(RAM_WAIT_CYC);
  localparam logic [WAIT_W-1:0] ROM_WAIT = WAIT_W'(ROM_WAIT_CYC);

  // Module control register fields
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam int MCR_DIGIT_MSB = 3;
  localparam int MCR_DISP_ON = 4;
  localparam int MCR_BLK_XFER = 5;
  localparam int MCR_BR_TO_EN = 6;
  localparam int MCR_DT_TO_EN = 7;
  localparam logic [3:0] DIGIT_SYSFAIL = 4'hF;

  // Address blocks and segments
  localparam logic [3:0] LO_BLOCK_NIB = 4'h0;
  localparam logic [3:0] HI_BLOCK_NIB = 4'hF;
  localparam int SEG_LSB = 12;
  localparam int BLK_MSB = 19;
  localparam int TBL_AW = 9;
  localparam int TBL_DEPTH = 512;

  // Decode table entry encoding
  localparam logic [3:0] ENT_VME_STD = 4'h0;
  localparam logic [3:0] ENT_VME_SHORT = 4'h1;
  localparam logic [3:0] ENT_LOCAL_IO = 4'h2;
  localparam int ENT_MEM_BIT = 3;
  localparam int ENT_ROM_BIT = 2;
  localparam logic [1:0] ROM_PAIR = 2'h3;

  // Delivered map, as table indices
  localparam logic [TBL_AW-1:0] MAP_RAM_END = 9'h003;
  localparam logic [TBL_AW-1:0] MAP_ROM_FIRST = 9'h100;
  localparam logic [TBL_AW-1:0] MAP_ROM_END = 9'h104;
  localparam logic [TBL_AW-1:0] MAP_IO_IDX = 9'h1E0;
  localparam logic [TBL_AW-1:0] MAP_SHORT_FIRST = 9'h1F0;

  // Local I/O decode
  localparam logic [23:0] MCR_ADDR = 24'hFE00F1;
  localparam int IO_SEL_LSB = 4;
  localparam int IO_SEL_MSB = 6;
  localparam logic [2:0] IO_DEV_MCR = MCR_ADDR[IO_SEL_MSB:IO_SEL_LSB];

  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_ACCESS = 2'h2} badc_fsm_type;
  typedef enum logic [6:0] {
    CLS_NONE = 7'h01, CLS_VME = 7'h02, CLS_MEM = 7'h04, CLS_IO = 7'h08,
    CLS_VIACK = 7'h10, CLS_AVIACK = 7'h20, CLS_RESET = 7'h40
  } badc_class_type;

  function automatic logic is_mid(input logic [23:0] a);
    is_mid = (a[23:20] != LO_BLOCK_NIB) && (a[23:20] != HI_BLOCK_NIB);
  endfunction

  function automatic logic [3:0] delivered_entry(input logic [TBL_AW-1:0] idx);
    if (idx < MAP_RAM_END) begin
      delivered_entry = {1'b1, 1'b0, idx[1:0]};
    end else if (idx >= MAP_ROM_FIRST && idx < MAP_ROM_END) begin
      delivered_entry = {1'b1, 1'b1, ROM_PAIR};
    end else if (idx == MAP_IO_IDX) begin
      delivered_entry = ENT_LOCAL_IO;
    end else if (idx >= MAP_SHORT_FIRST) begin
      delivered_entry = ENT_VME_SHORT;
    end else begin
      delivered_entry = ENT_VME_STD;
    end
  endfunction
endpackage

//--- core/badc_link_if.sv
// Purpose: carrier between the selector and its table and I/O decoder
// Assumes: purely combinational signals
// Notes: none
`timescale 1ns/1ps
interface badc_link_if;
  logic [8:0] tbl_idx;
  logic [3:0] tbl_entry;
  logic tbl_we;
  logic [8:0] tbl_waddr;
  logic [3:0] tbl_wdata;
  logic io_en;
  logic io_odd;
  logic [2:0] io_slot;
  logic [7:0] io_sel;
  modport tbl (input tbl_idx, tbl_we, tbl_waddr, tbl_wdata, output tbl_entry);
  modport io (input io_en, io_odd, io_slot, output io_sel);
  modport host (output tbl_idx, tbl_we, tbl_waddr, tbl_wdata, io_en, io_odd, io_slot,
                input tbl_entry, io_sel);
endinterface

//--- core/badc_decode_table.sv
// Purpose: loadable segment decode table
// Assumes: synchronous active-low reset restores the delivered map
// Notes: flip-flop storage, combinational read
`timescale 1ns/1ps
module badc_decode_table import badc_pkg::*; (
  input wire logic i_clock,
  input wire logic i_nrst,
  badc_link_if.tbl lnk
);
  typedef struct packed {
    logic [TBL_DEPTH-1:0][3:0] ent;
  } badc_tbl_state_type;

  badc_tbl_state_type st;
  badc_tbl_state_type nxt;

  always_comb begin
    nxt = st;
    if (!i_nrst) begin
      for (int i = 0; i < TBL_DEPTH; i++) begin
        nxt.ent[i] = delivered_entry(TBL_AW'(i)); // RULE23
      end
    end else if (lnk.tbl_we) begin
      nxt.ent[lnk.tbl_waddr] = lnk.tbl_wdata; // RULE25
    end
  end

  always_ff @(posedge i_clock) begin
    st <= nxt;
  end

  assign lnk.tbl_entry = st.ent[lnk.tbl_idx]; // RULE18
endmodule

//--- core/badc_io_decode.sv
// Purpose: local I/O device select from the low address bits
// Assumes: enable already qualified by valid memory address
// Notes: partial decode, register set repeats across the segment
`timescale 1ns/1ps
module badc_io_decode import badc_pkg::*; (
  badc_link_if.io lnk
);
  always_comb begin
    lnk.io_sel = 8'h00;
    // Even addresses select nothing
    if (lnk.io_en && lnk.io_odd) begin
      lnk.io_sel[lnk.io_slot] = 1'b1; // RULE21 RULE22
    end
  end
endmodule

//--- core/badc_top.sv
// Purpose: address decoder, cycle selector and module control register
// Assumes: processor strobes are on the board clock; i_cycle_valid spans a bus cycle
// Notes: all outputs registered and active high
// Functional notes
// RULE1: a write to the control register stores the low data byte.
// RULE2: the control register reads back its stored byte.
// RULE3: low four control bits give the status display hex digit.
// RULE4: digit F asserts the system fail line; other digits leave it negated.
// RULE5: control bit 4 lights the status display, zero blanks it.
// RULE6: control bit 5 drives the block transfer request.
// RULE7: bits 6 and 7 enable bus-request and data-transfer time-outs.
// RULE8: reset clears the control register, blanking the display.
// RULE9: processor halt clears the control register and lights both decimal points.
// RULE10: control outputs are active high.
// RULE11: each cycle is classified from table, processor, interrupt and reset inputs.
// RULE12: bus cycles enable both the bus requester and bus interface.
// RULE13: memory cycles select the pair and raise the transfer acknowledge.
// RULE14: I/O and auto-vector cycles assert valid peripheral address, not acknowledge.
// RULE15: valid memory address then enables the local I/O decoder.
// RULE16: address space splits into low, middle and high blocks.
// RULE17: outside reset fetches and interrupt acknowledges, the middle block goes off-board, bypassing the table.
// RULE18: low and high blocks use 4K segments indexing a 512-entry table.
// RULE19: memory entries choose ROM or RAM acknowledge timing.
// RULE20: off-board segments may be tagged for short I/O addressing.
// RULE21: I/O registers answer only at odd addresses on the low byte.
// RULE22: only address bits 4 to 6 select the I/O device.
// RULE23: reset loads the delivered map into the table.
// RULE24: the control register sits at device slot of its fixed address.
// RULE25: the table is a loadable lookup with a local encoding.
`timescale 1ns/1ps
module badc_top import badc_pkg::*; (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_cycle_valid,
  input wire logic i_write,
  input wire logic [23:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_iack,
  input wire logic i_iack_vme,
  input wire logic i_reset_fetch,
  input wire logic i_vma,
  input wire logic i_halted,
  input wire logic i_tbl_we,
  input wire logic [8:0] i_tbl_addr,
  input wire logic [3:0] i_tbl_wdata,
  output logic [7:0] o_rdata,
  output logic o_vme_req_en,
  output logic o_vme_if_en,
  output logic o_short_io,
  output logic [3:0] o_mem_pair_sel,
  output logic o_rom_timing,
  output logic o_dtack,
  output logic o_valid_peripheral_address,
  output logic [7:0] o_io_dev_sel,
  output logic [3:0] o_status_digit,
  output logic o_status_display_on,
  output logic o_decimal_points,
  output logic o_sysfail,
  output logic o_block_transfer_request,
  output logic o_bus_request_timeout_enable,
  output logic o_data_transfer_timeout_enable
);
  typedef struct packed {
    badc_fsm_type fsm;
    badc_class_type cls;
    logic [WAIT_W-1:0] wait_cnt;
    logic [7:0] module_control;
    logic sysfail;
    logic dec_points;
    logic wr_done;
    logic vme_req_en;
    logic vme_if_en;
    logic short_io;
    logic [3:0] mem_pair;
    logic rom_timing;
    logic dtack;
    logic vpa;
    logic [7:0] io_sel;
    logic [7:0] rdata;
  } badc_state_type;

  localparam badc_state_type ST_RESET = '{
    fsm: ST_IDLE, cls: CLS_NONE, wait_cnt: '0, module_control: MCR_RESET, sysfail: 1'b0,
    dec_points: 1'b0, wr_done: 1'b0, vme_req_en: 1'b0, vme_if_en: 1'b0,
    short_io: 1'b0, mem_pair: 4'h0, rom_timing: 1'b0, dtack: 1'b0, vpa: 1'b0,
    io_sel: 8'h00, rdata: 8'h00};

  badc_state_type st;
  badc_state_type nxt;
  badc_class_type cls_now;
  logic mid_now;
  logic mcr_hit;

  badc_link_if lnk ();

  badc_decode_table u_table (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .lnk(lnk.tbl)
  );

  badc_io_decode u_io (
    .lnk(lnk.io)
  );

  function automatic logic [3:0] pair_onehot(input logic [1:0] p);
    pair_onehot = 4'h1 << p;
  endfunction

  function automatic badc_class_type classify(input logic rst_fetch, input logic iack,
                                              input logic iack_vme, input logic mid,
                                              input logic [3:0] ent);
    if (rst_fetch) begin
      classify = CLS_RESET;
    end else if (iack) begin
      classify = iack_vme ? CLS_VIACK : CLS_AVIACK;
    end else if (mid) begin
      classify = CLS_VME; // RULE17
    end else if (ent[ENT_MEM_BIT]) begin
      classify = CLS_MEM;
    end else if (ent == ENT_LOCAL_IO) begin
      classify = CLS_IO;
    end else begin
      classify = CLS_VME;
    end
  endfunction

  assign mid_now = is_mid(i_addr); // RULE16
  assign lnk.tbl_idx = {i_addr[23], i_addr[BLK_MSB:SEG_LSB]}; // RULE18
  assign lnk.tbl_we = i_tbl_we;
  assign lnk.tbl_waddr = i_tbl_addr;
  assign lnk.tbl_wdata = i_tbl_wdata;
  // Decoder only opens once the processor has synchronised
  assign lnk.io_en = (st.fsm == ST_ACCESS) && (st.cls == CLS_IO) && i_vma; // RULE15
  assign lnk.io_odd = i_addr[0];
  assign lnk.io_slot = i_addr[IO_SEL_MSB:IO_SEL_LSB];
  assign mcr_hit = lnk.io_sel[IO_DEV_MCR]; // RULE24
  assign cls_now = classify(i_reset_fetch, i_iack, i_iack_vme, mid_now, lnk.tbl_entry); // RULE11

  always_comb begin
    nxt = st;
    unique case (st.fsm)
      ST_IDLE: begin
        if (i_cycle_valid) begin
          nxt.fsm = ST_ACCESS;
          nxt.cls = cls_now;
          nxt.wr_done = 1'b0;
          unique case (cls_now)
            CLS_VME, CLS_VIACK: begin
              nxt.vme_req_en = 1'b1; // RULE12
              nxt.vme_if_en = 1'b1;
              nxt.short_io = (cls_now == CLS_VME) && !mid_now &&
                             (lnk.tbl_entry == ENT_VME_SHORT); // RULE20
            end
            CLS_MEM: begin
              nxt.mem_pair = pair_onehot(lnk.tbl_entry[1:0]); // RULE13
              nxt.rom_timing = lnk.tbl_entry[ENT_ROM_BIT]; // RULE19
              nxt.wait_cnt = lnk.tbl_entry[ENT_ROM_BIT] ? ROM_WAIT : RAM_WAIT;
            end
            CLS_RESET: begin
              // Reset vectors come from the ROM pair whatever the address
              nxt.mem_pair = pair_onehot(ROM_PAIR);
              nxt.rom_timing = 1'b1;
              nxt.wait_cnt = ROM_WAIT;
            end
            CLS_IO, CLS_AVIACK: begin
              nxt.vpa = 1'b1; // RULE14
            end
            default: begin
              nxt.cls = CLS_NONE;
            end
          endcase
        end
      end
      ST_ACCESS: begin
        if (!i_cycle_valid) begin
          nxt.fsm = ST_IDLE;
          nxt.cls = CLS_NONE;
          nxt.vme_req_en = 1'b0;
          nxt.vme_if_en = 1'b0;
          nxt.short_io = 1'b0;
          nxt.mem_pair = 4'h0;
          nxt.rom_timing = 1'b0;
          nxt.dtack = 1'b0;
          nxt.vpa = 1'b0;
          nxt.io_sel = 8'h00;
          nxt.rdata = 8'h00;
          nxt.wait_cnt = '0;
        end else begin
          if ((st.cls == CLS_MEM) || (st.cls == CLS_RESET)) begin
            if (st.wait_cnt == '0) begin
              nxt.dtack = 1'b1; // RULE13
            end else begin
              nxt.wait_cnt = st.wait_cnt - WAIT_W'(1);
            end
          end
          nxt.io_sel = lnk.io_sel; // RULE15
          if (mcr_hit && i_write && !st.wr_done) begin
            nxt.module_control = i_wdata; // RULE1
            nxt.wr_done = 1'b1;
          end
          // Read data shows the stored byte only in cycles where the register is selected for a read
          nxt.rdata = (mcr_hit && !i_write) ? st.module_control : 8'h00; // RULE2
        end
      end
      default: begin
        nxt = ST_RESET;
      end
    endcase
    // Halt wins over a write in the same cycle; points stay lit until reset
    if (i_halted) begin
      nxt.module_control = MCR_RESET; // RULE9
      nxt.dec_points = 1'b1;
    end
    nxt.sysfail = (nxt.module_control[MCR_DIGIT_MSB:0] == DIGIT_SYSFAIL); // RULE4
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st <= ST_RESET; // RULE8
    end else begin
      st <= nxt;
    end
  end

  assign o_rdata = st.rdata;
  assign o_vme_req_en = st.vme_req_en;
  assign o_vme_if_en = st.vme_if_en;
  assign o_short_io = st.short_io;
  assign o_mem_pair_sel = st.mem_pair;
  assign o_rom_timing = st.rom_timing;
  assign o_dtack = st.dtack;
  assign o_valid_peripheral_address = st.vpa;
  assign o_io_dev_sel = st.io_sel;
  assign o_status_digit = st.module_control[MCR_DIGIT_MSB:0]; // RULE3
  assign o_status_display_on = st.module_control[MCR_DISP_ON]; // RULE5
  assign o_decimal_points = st.dec_points;
  assign o_sysfail = st.sysfail;
  assign o_block_transfer_request = st.module_control[MCR_BLK_XFER]; // RULE6
  assign o_bus_request_timeout_enable = st.module_control[MCR_BR_TO_EN]; // RULE7
  assign o_data_transfer_timeout_enable = st.module_control[MCR_DT_TO_EN]; // RULE10

  // Checks
  localparam int A_DT_MAX = 8;

  sequence s_start;
    (st.fsm == ST_IDLE) && i_cycle_valid;
  endsequence

  sequence s_mem_start;
    s_start ##0 (cls_now == CLS_MEM);
  endsequence

  sequence s_io_start;
    s_start ##0 ((cls_now == CLS_IO) || (cls_now == CLS_AVIACK));
  endsequence

  sequence s_mcr_write;
    (st.fsm == ST_ACCESS) && i_cycle_valid && mcr_hit && i_write && !st.wr_done && !i_halted;
  endsequence

  // Counts follow RAM_WAIT and ROM_WAIT; retune them together
  sequence s_ram_wait;
    (s_mem_start ##0 !lnk.tbl_entry[ENT_ROM_BIT]) ##1 i_cycle_valid [*3];
  endsequence

  sequence s_rom_fetch_wait;
    (s_start ##0 (cls_now == CLS_RESET)) ##1 i_cycle_valid [*6];
  endsequence

  a_mcr_write_capture: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE1
    s_mcr_write |=> (st.module_control == $past(i_wdata)))
    else $error("control register did not capture write data");

  a_mcr_read_back: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE2
    ((st.fsm == ST_ACCESS) && i_cycle_valid && mcr_hit && !i_write) |=>
    (o_rdata == $past(st.module_control)))
    else $error("control register read returned wrong byte");

  a_sysfail_digit: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE4
    s_mcr_write |=> (o_sysfail == ($past(i_wdata[MCR_DIGIT_MSB:0]) == DIGIT_SYSFAIL)))
    else $error("system fail does not follow digit F");

  a_reset_clears: assert property (@(posedge i_clock) // RULE8
    !i_nrst |=> (st.module_control == MCR_RESET) && !o_status_display_on && !o_dtack)
    else $error("reset did not clear control register");

  a_halt_clears: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE9
    i_halted |=> (st.module_control == MCR_RESET) && o_decimal_points && !o_sysfail)
    else $error("halt did not clear register and light points");

  a_mid_goes_vme: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE17
    (s_start ##0 (mid_now && !i_iack && !i_reset_fetch)) |=>
    (o_vme_req_en && o_vme_if_en && !o_short_io && (o_mem_pair_sel == 4'h0)))
    else $error("middle block cycle not sent off-board");

  a_mem_dtack: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE13
    s_mem_start |=> ($countones(o_mem_pair_sel) == 1) ##[1:A_DT_MAX]
    (o_dtack || !i_cycle_valid))
    else $error("memory cycle lacks pair select or acknowledge");

  a_rom_timing: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE19
    (s_mem_start ##0 !lnk.tbl_entry[ENT_ROM_BIT]) |=>
    !o_rom_timing ##1 (!o_dtack || !i_cycle_valid))
    else $error("RAM cycle used ROM timing or acknowledged too early");

  a_vpa_io: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE14
    s_io_start |=> (o_valid_peripheral_address && !o_dtack) ##1
    (!i_cycle_valid || (o_valid_peripheral_address && !o_dtack)))
    else $error("I/O cycle without valid peripheral address");

  a_io_odd_only: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE21
    (o_io_dev_sel != 8'h00) |-> $past(i_addr[0]) && $past(i_vma) &&
    (o_io_dev_sel == (8'h01 << $past(i_addr[IO_SEL_MSB:IO_SEL_LSB]))))
    else $error("I/O device selected at even address or wrong slot");

  a_ctrl_bits: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE10
    s_mcr_write |=> (o_block_transfer_request == $past(i_wdata[MCR_BLK_XFER])) &&
    (o_bus_request_timeout_enable == $past(i_wdata[MCR_BR_TO_EN])) &&
    (o_data_transfer_timeout_enable == $past(i_wdata[MCR_DT_TO_EN])) &&
    (o_status_display_on == $past(i_wdata[MCR_DISP_ON])))
    else $error("control outputs not active high");

  // One settle edge after the count reaches zero
  a_ram_dtack_time: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE19
    s_ram_wait |=> o_dtack && !o_rom_timing)
    else $error("RAM cycle acknowledge not on time");

  a_rom_dtack_time: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE19
    s_rom_fetch_wait |=> o_dtack && o_rom_timing && (o_mem_pair_sel == pair_onehot(ROM_PAIR)))
    else $error("reset fetch acknowledge not on time");

  // A missed clear would let the next cycle start already acknowledged
  a_cycle_clear: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE12
    ((st.fsm == ST_ACCESS) && !i_cycle_valid) |=> !o_dtack && !o_valid_peripheral_address &&
    !o_vme_req_en && !o_vme_if_en && (o_mem_pair_sel == 4'h0) && (o_io_dev_sel == 8'h00))
    else $error("cycle outputs not cleared after cycle end");

  a_io_no_bus: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE14
    s_io_start |=> !o_vme_req_en && !o_vme_if_en && (o_mem_pair_sel == 4'h0))
    else $error("I/O cycle also enabled bus or memory");

  // Only reset may darken the points
  a_points_sticky: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE9
    o_decimal_points |=> o_decimal_points)
    else $error("decimal points went dark before reset");
endmodule

//--- tb/badc_host_model.sv
// Purpose: processor model that runs local bus cycles into the decode block
// Assumes: all drives land 1 ns after the rising clock edge
// Notes: a cycle is split into start (wait for answer) and finish (release and idle)
`timescale 1ns/1ps
module badc_host_model (
  input wire logic i_clock,
  input wire logic i_dtack,
  input wire logic i_vpa,
  input wire logic i_vme_req_en,
  input wire logic [7:0] i_rdata,
  input wire logic [7:0] i_io_dev_sel,
  output logic o_cycle_valid,
  output logic o_write,
  output logic [23:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_iack,
  output logic o_iack_vme,
  output logic o_reset_fetch,
  output logic o_vma
);
  initial begin
    o_cycle_valid = 1'b0;
    o_write = 1'b0;
    o_addr = 24'h000000;
    o_wdata = 8'h00;
    {o_iack, o_iack_vme, o_reset_fetch} = 3'b000;
    o_vma = 1'b0;
  end

  task automatic start(input logic [23:0] a, input logic w, input logic [7:0] d,
                       input logic [2:0] k, output logic [7:0] rd, output logic [7:0] sel);
    int n;
    n = 0;
    rd = 8'h00;
    sel = 8'h00;
    o_addr = a;
    o_write = w;
    o_wdata = d;
    {o_iack, o_iack_vme, o_reset_fetch} = k;
    o_cycle_valid = 1'b1;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while (!(i_dtack === 1'b1 || i_vpa === 1'b1 || i_vme_req_en === 1'b1) && n < 12);
    if (i_vpa === 1'b1) begin
      // Peripheral handshake: valid memory address only after valid peripheral address answers
      o_vma = 1'b1;
      @(posedge i_clock);
      #1;
      rd = i_rdata;
      sel = i_io_dev_sel;
    end
  endtask

  task automatic finish();
    o_cycle_valid = 1'b0;
    o_vma = 1'b0;
    {o_iack, o_iack_vme, o_reset_fetch} = 3'b000;
    // Released bus must not keep showing the old value
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
    repeat (2) @(posedge i_clock);
    #1;
  endtask
endmodule

//--- tb/badc_top_tb.sv
// Purpose: self-checking bench for the decode, selector and control register block
// Assumes: delivered map after reset, entry encoding from the package
// Notes: random control bytes and addresses from an xorshift seeded with 9
`timescale 1ns/1ps
module badc_top_tb;
  import badc_pkg::*;
  logic i_clock = 1'b0, i_nrst = 1'b0, i_halted = 1'b0, i_tbl_we = 1'b0;
  logic [8:0] i_tbl_addr = 9'h000;
  logic [3:0] i_tbl_wdata = 4'h0;
  logic i_cycle_valid, i_write, i_iack, i_iack_vme, i_reset_fetch, i_vma;
  logic [23:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_io_dev_sel, rd;
  logic o_vme_req_en, o_vme_if_en, o_short_io, o_rom_timing, o_dtack;
  logic o_valid_peripheral_address, o_status_display_on, o_decimal_points, o_sysfail;
  logic o_block_transfer_request, o_bus_request_timeout_enable;
  logic o_data_transfer_timeout_enable;
  logic [3:0] o_mem_pair_sel, o_status_digit;
  logic [31:0] seed = 32'h9;
  int fail_count = 0, total_checks = 0;

  always #5 i_clock = ~i_clock;

  badc_top badc_top_i (.i_clock, .i_nrst, .i_cycle_valid, .i_write, .i_addr, .i_wdata,
    .i_iack, .i_iack_vme, .i_reset_fetch, .i_vma, .i_halted, .i_tbl_we, .i_tbl_addr,
    .i_tbl_wdata, .o_rdata, .o_vme_req_en, .o_vme_if_en, .o_short_io, .o_mem_pair_sel,
    .o_rom_timing, .o_dtack, .o_valid_peripheral_address, .o_io_dev_sel, .o_status_digit,
    .o_status_display_on, .o_decimal_points, .o_sysfail, .o_block_transfer_request,
    .o_bus_request_timeout_enable, .o_data_transfer_timeout_enable);

  badc_host_model badc_host_model_i (.i_clock, .i_dtack(o_dtack),
    .i_vpa(o_valid_peripheral_address), .i_vme_req_en(o_vme_req_en), .i_rdata(o_rdata),
    .i_io_dev_sel(o_io_dev_sel), .o_cycle_valid(i_cycle_valid), .o_write(i_write),
    .o_addr(i_addr), .o_wdata(i_wdata), .o_iack(i_iack), .o_iack_vme(i_iack_vme),
    .o_reset_fetch(i_reset_fetch), .o_vma(i_vma));

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Packed as {bus, short, pair[3:0], rom, vpa}
  function automatic logic [7:0] exp_route(input logic [23:0] a, input logic [2:0] k);
    if (k[0]) return 8'h22;
    if (k[2]) return k[1] ? 8'h80 : 8'h01;
    if (a[23:20] != 4'h0 && a[23:20] != 4'hF) return 8'h80;
    if (a < 24'h003000) return {2'b00, 4'h1 << a[13:12], 2'b00};
    if (a >= 24'hF00000 && a < 24'hF04000) return 8'h22;
    if (a[23:12] == 12'hFE0) return 8'h01;
    if (a >= 24'hFF0000) return 8'hC0;
    return 8'h80;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic route(input logic [23:0] a, input logic [2:0] k, input logic [7:0] e);
    logic [7:0] r, s;
    badc_host_model_i.start(a, 1'b0, 8'h00, k, r, s);
    check({o_vme_req_en, o_short_io, o_mem_pair_sel, o_rom_timing,
           o_valid_peripheral_address}, e);
    check(o_vme_if_en, e[7]);
    check(o_dtack, |e[5:2]);
    badc_host_model_i.finish();
  endtask

  task automatic io(input logic [23:0] a, input logic w, input logic [7:0] d,
                    input logic [7:0] esel);
    logic [7:0] s;
    badc_host_model_i.start(a, w, d, 3'b000, rd, s);
    check(s, esel);
    badc_host_model_i.finish();
  endtask

  task automatic mcr_check(input logic [7:0] v);
    check({o_data_transfer_timeout_enable, o_bus_request_timeout_enable,
           o_block_transfer_request, o_status_display_on, o_status_digit}, v);
    check(o_sysfail, v[3:0] == 4'hF);
    io(MCR_ADDR, 1'b0, 8'h00, 8'h80);
    check(rd, v);
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  logic [23:0] addrs [14] = '{24'h000000, 24'h001234, 24'h002FFE, 24'h003000, 24'h0FFFFE,
    24'h100000, 24'hEFFFFE, 24'hF00000, 24'hF03FFE, 24'hF04000, 24'hFE0001, 24'hFEFFFE,
    24'hFF0000, 24'hFFFFFE};
  logic [3:0] ents [3] = '{4'h9, 4'hC, ENT_VME_SHORT};
  logic [7:0] ent_exp [3] = '{8'h08, 8'h06, 8'hC0};
  logic [7:0] corners [4] = '{8'h0F, 8'hFF, 8'h00, 8'h1E};

  initial begin
    logic [7:0] v;
    logic [23:0] a;
    repeat (6) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    check(o_decimal_points, 1'b0);
    mcr_check(8'h00);
    $display("Test reset done");
    foreach (addrs[i]) route(addrs[i], 3'b000, exp_route(addrs[i], 3'b000));
    route(24'h123456, 3'b001, 8'h22);
    route(24'hFFFFF8, 3'b100, 8'h01);
    route(24'hFFFFF8, 3'b110, 8'h80);
    repeat (20) begin
      a = 24'(xorshift());
      a[0] = 1'b0;
      route(a, 3'b000, exp_route(a, 3'b000));
    end
    $display("Test routing done");
    for (int i = 0; i < 16; i++) begin
      v = (i < 4) ? corners[i] : 8'(xorshift());
      a = {12'hFE0, 5'(xorshift()), 7'h71};
      io(a, 1'b1, v, 8'h80);
      mcr_check(v);
      io(24'hFE00F0, 1'b1, ~v, 8'h00);
      io(24'hFE00E1, 1'b1, ~v, 8'h40);
      mcr_check(v);
    end
    $display("Test control register done");
    foreach (ents[i]) begin
      i_tbl_addr = 9'h010;
      i_tbl_wdata = ents[i];
      i_tbl_we = 1'b1;
      @(posedge i_clock);
      #1;
      i_tbl_we = 1'b0;
      route(24'h010000, 3'b000, ent_exp[i]);
      route(24'h110000, 3'b000, 8'h80);
    end
    $display("Test table load done");
    io(MCR_ADDR, 1'b1, 8'hFF, 8'h80);
    i_halted = 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    i_halted = 1'b0;
    check(o_decimal_points, 1'b1);
    mcr_check(8'h00);
    i_nrst = 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    check(o_decimal_points, 1'b0);
    mcr_check(8'h00);
    route(24'h010000, 3'b000, 8'h80);
    $display("Test halt and reset done");
    wrap_up();
  end

  initial begin
    #500000;
    fail_count++;
    wrap_up();
  end
endmodule
